// >>> include/mbs_params.svh
// Constants of the Modbus slave request handler
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH

// Supported function codes
`define MBS_FC_RD_COILS 8'h01
`define MBS_FC_RD_DIN 8'h02
`define MBS_FC_RD_HREG 8'h03
`define MBS_FC_RD_IREG 8'h04
`define MBS_FC_WR_COIL 8'h05
`define MBS_FC_WR_HREG 8'h06
`define MBS_FC_WR_COILS 8'h0f

// Exception codes and the flag set in the echoed function code
`define MBS_EX_ILL_FUNC 8'h01
`define MBS_EX_ILL_ADDR 8'h02
`define MBS_EX_ILL_VALUE 8'h03
`define MBS_EX_DEV_FAIL 8'h04
`define MBS_EX_ACK 8'h05
`define MBS_EX_BUSY 8'h06
`define MBS_EX_NAK 8'h07
`define MBS_EX_PARITY 8'h08
`define MBS_EXC_FLAG 8'h80

// Coil values of a single coil write
`define MBS_COIL_ON 16'hff00
`define MBS_COIL_OFF 16'h0000

// Object counts
`define MBS_NUM_COILS 17'd16
`define MBS_NUM_REGS 17'd8

// Frame sizes in bytes
`define MBS_RX_DEPTH 16
`define MBS_TX_DEPTH 20
`define MBS_FIXED_LEN 5'd8
`define MBS_MULTI_LEN 5'd9
`define MBS_EXC_LEN 5'd3
`define MBS_ECHO_LEN 5'd6

// Reset values, slave address and CRC
`define MBS_COIL_RST 16'h0000
`define MBS_HREG_RST 16'h0000
`define MBS_SLAVE_ADDR 8'h01
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001

`endif

// >>> include/mbs_pkg.sv
// Types of the Modbus slave request handler
`default_nettype none

package mbs_pkg;
  typedef enum logic [1:0] {
    ST_RECV,
    ST_EXEC,
    ST_SEND
  } mbs_state_e;
endpackage : mbs_pkg

`default_nettype wire

// >>> rtl/mbs_request_handler.sv
// Modbus slave request handler: frame in, decode, execute, answer out
// Summary of operation
// - Device only answers queries; it never starts traffic on its own.
// - Function 01 returns the on/off states of the coils.
// - Function 02 returns the states of the digital inputs.
// - Function 03 returns holding registers as 16-bit words.
// - Function 04 returns input registers as 16-bit words.
// - Function 05 forces one addressed coil on or off.
// - Function 06 writes one 16-bit value into one register.
// - Function 15 forces a run of consecutive coils to supplied states.
// - Unsupported function code answers with exception 01.
// - Invalid referenced address answers with exception 02.
// - Value out of permitted range answers with exception 03.
// - Unrecoverable fault during a write (05, 06, 15) answers with exception 04.
// - Accepted long-running request answers with exception 05.
// - Request during a long program command answers with exception 06, unless its function code is unsupported.
// - Program function that cannot be done answers with exception 07.
// - Memory parity error on a register read (03, 04) answers with exception 08.
// - Exception answer echoes the function code with its top bit set.
// - Exception answer is address, function, exception code, then CRC.
// - Sender computes a CRC over the whole message and appends it.
// - Receiver recomputes the CRC on arrival and compares with received.
`include "mbs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mbs_request_handler #(
  parameter logic [7:0] SLAVE_ADDR = `MBS_SLAVE_ADDR
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Request byte stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  // Response byte stream
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  // Process data
  input wire logic [15:0] din_i,
  input wire logic [127:0] ireg_i,
  output logic [15:0] coil_o,
  output logic [127:0] hreg_o,
  // Device condition
  input wire logic fault_i,
  input wire logic long_op_i,
  input wire logic prog_busy_i,
  input wire logic prog_nak_i,
  input wire logic parity_err_i
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  mbs_pkg::mbs_state_e state_ff, nxt_state;
  logic [7:0] rx_buf_ff [`MBS_RX_DEPTH];
  logic [7:0] nxt_rx_buf [`MBS_RX_DEPTH];
  logic [4:0] rx_cnt_ff, nxt_rx_cnt;
  logic rx_ovf_ff, nxt_rx_ovf;
  logic [15:0] crc_ff, nxt_crc, crc_d1_ff, nxt_crc_d1, crc_d2_ff, nxt_crc_d2;
  logic [7:0] tx_buf_ff [`MBS_TX_DEPTH];
  logic [7:0] nxt_tx_buf [`MBS_TX_DEPTH];
  logic [4:0] tx_len_ff, nxt_tx_len, tx_idx_ff, nxt_tx_idx;
  logic [15:0] tx_crc_ff, nxt_tx_crc;
  logic [7:0] tx_data_ff, nxt_tx_data;
  logic tx_last_ff, nxt_tx_last;
  logic [15:0] coil_ff, nxt_coil;
  logic [15:0] hreg_ff [8];
  logic [15:0] nxt_hreg [8];
  logic [15:0] din_s1_ff, din_s2_ff, din_s3_ff, din_ff, nxt_din;
  logic [7:0] exc_ff, nxt_exc;
  logic frame_ok;

  // Reflected CRC-16 step over one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////
  // Request field views
  logic [7:0] fc;
  logic [15:0] start, qty;
  logic [7:0] bcnt;
  logic [16:0] end_addr;
  logic [4:0] nbytes;
  logic [15:0] rx_crc;
  assign fc = rx_buf_ff[1];
  assign start = {rx_buf_ff[2], rx_buf_ff[3]};
  assign qty = {rx_buf_ff[4], rx_buf_ff[5]};
  assign bcnt = rx_buf_ff[6];
  assign end_addr = {1'b0, start} + {1'b0, qty};
  assign nbytes = (qty > 16'h0008) ? 5'd2 : 5'd1;
  assign rx_crc = {rx_buf_ff[4'(rx_cnt_ff - 5'd1)], rx_buf_ff[4'(rx_cnt_ff - 5'd2)]};

  // Frame acceptance: own address, sane length, CRC match
  always_comb begin
    frame_ok = !rx_ovf_ff && (rx_cnt_ff >= 5'd4) && (rx_buf_ff[0] == SLAVE_ADDR);
    if (crc_d2_ff != rx_crc) begin
      frame_ok = 1'b0;
    end
    if (fc == `MBS_FC_WR_COILS) begin
      if (rx_cnt_ff != `MBS_MULTI_LEN + 5'(bcnt)) begin
        frame_ok = 1'b0;
      end
    end else if (fc >= `MBS_FC_RD_COILS && fc <= `MBS_FC_WR_HREG) begin
      if (rx_cnt_ff != `MBS_FIXED_LEN) begin
        frame_ok = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sync: three flops, change taken when second and third agree
  always_comb begin
    nxt_din = din_ff;
    for (int b = 0; b < 16; b++) begin
      if (din_s2_ff[b] == din_s3_ff[b]) begin
        nxt_din[b] = din_s3_ff[b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute: decode, check, perform writes, build answer
  always_comb begin
    logic [15:0] bits;
    logic [2:0] ri;
    logic [4:0] off;
    bits = 16'h0000;
    ri = 3'd0;
    off = 5'd0;
    nxt_exc = 8'h00;
    nxt_tx_len = `MBS_ECHO_LEN;
    nxt_tx_buf = tx_buf_ff;
    nxt_coil = coil_ff;
    nxt_hreg = hreg_ff;
    nxt_tx_buf[0] = SLAVE_ADDR;
    nxt_tx_buf[1] = fc;
    for (int i = 2; i < 6; i++) begin
      nxt_tx_buf[i] = rx_buf_ff[i];
    end
    if (fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_DIN) begin
      if (qty == 16'h0000 || qty > 16'h0010) begin
        nxt_exc = `MBS_EX_ILL_VALUE;
      end else if (end_addr > `MBS_NUM_COILS) begin
        nxt_exc = `MBS_EX_ILL_ADDR;
      end else begin
        bits = ((fc == `MBS_FC_RD_COILS) ? coil_ff : din_ff) >> start[3:0];
        bits = bits & (16'hffff >> (5'd16 - qty[4:0]));
        nxt_tx_buf[2] = 8'(nbytes);
        nxt_tx_buf[3] = bits[7:0];
        nxt_tx_buf[4] = bits[15:8];
        nxt_tx_len = 5'd3 + nbytes;
      end
    end else if (fc == `MBS_FC_RD_HREG || fc == `MBS_FC_RD_IREG) begin
      if (qty == 16'h0000 || qty > 16'h0008) begin
        nxt_exc = `MBS_EX_ILL_VALUE;
      end else if (end_addr > `MBS_NUM_REGS) begin
        nxt_exc = `MBS_EX_ILL_ADDR;
      end else if (parity_err_i) begin
        nxt_exc = `MBS_EX_PARITY;
      end else begin
        for (int i = 0; i < 8; i++) begin
          ri = start[2:0] + 3'(i);
          bits = (fc == `MBS_FC_RD_HREG) ? hreg_ff[ri] : ireg_i[{ri, 4'h0} +: 16];
          nxt_tx_buf[3 + 2 * i] = bits[15:8];
          nxt_tx_buf[4 + 2 * i] = bits[7:0];
        end
        nxt_tx_buf[2] = {qty[6:0], 1'b0};
        nxt_tx_len = 5'd3 + {qty[3:0], 1'b0};
      end
    end else if (fc == `MBS_FC_WR_COIL) begin
      if (qty != `MBS_COIL_ON && qty != `MBS_COIL_OFF) begin
        nxt_exc = `MBS_EX_ILL_VALUE;
      end else if ({1'b0, start} >= `MBS_NUM_COILS) begin
        nxt_exc = `MBS_EX_ILL_ADDR;
      end else if (fault_i) begin
        nxt_exc = `MBS_EX_DEV_FAIL;
      end else begin
        nxt_coil[start[3:0]] = (qty == `MBS_COIL_ON);
      end
    end else if (fc == `MBS_FC_WR_HREG) begin
      if ({1'b0, start} >= `MBS_NUM_REGS) begin
        nxt_exc = `MBS_EX_ILL_ADDR;
      end else if (fault_i) begin
        nxt_exc = `MBS_EX_DEV_FAIL;
      end else begin
        nxt_hreg[start[2:0]] = qty;
      end
    end else if (fc == `MBS_FC_WR_COILS) begin
      if (qty == 16'h0000 || qty > 16'h0010 || bcnt != 8'(nbytes)) begin
        nxt_exc = `MBS_EX_ILL_VALUE;
      end else if (end_addr > `MBS_NUM_COILS) begin
        nxt_exc = `MBS_EX_ILL_ADDR;
      end else if (fault_i) begin
        nxt_exc = `MBS_EX_DEV_FAIL;
      end else begin
        bits = {rx_buf_ff[8], rx_buf_ff[7]};
        for (int i = 0; i < 16; i++) begin
          off = 5'(i) - start[4:0];
          if (17'(i) >= {1'b0, start} && 17'(i) < end_addr) begin
            nxt_coil[i] = bits[off[3:0]];
          end
        end
      end
    end else begin
      nxt_exc = `MBS_EX_ILL_FUNC;
    end
    // Program condition overrides the request checks other than illegal function
    if (nxt_exc != `MBS_EX_ILL_FUNC) begin
      if (prog_busy_i) begin
        nxt_exc = `MBS_EX_BUSY;
      end else if (prog_nak_i) begin
        nxt_exc = `MBS_EX_NAK;
      end
    end
    // Errors leave storage untouched; long operations still proceed
    if (nxt_exc != 8'h00) begin
      nxt_coil = coil_ff;
      nxt_hreg = hreg_ff;
    end else if (long_op_i) begin
      nxt_exc = `MBS_EX_ACK;
    end
    if (nxt_exc != 8'h00) begin
      nxt_tx_buf[1] = fc | `MBS_EXC_FLAG;
      nxt_tx_buf[2] = nxt_exc;
      nxt_tx_len = `MBS_EXC_LEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive, sequence and transmit next values
  always_comb begin
    logic [15:0] c;
    c = crc_step(tx_crc_ff, tx_data_ff);
    nxt_state = state_ff;
    nxt_rx_buf = rx_buf_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_ovf = rx_ovf_ff;
    nxt_crc = crc_ff;
    nxt_crc_d1 = crc_d1_ff;
    nxt_crc_d2 = crc_d2_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_tx_crc = tx_crc_ff;
    nxt_tx_data = tx_data_ff;
    nxt_tx_last = tx_last_ff;
    case (state_ff)
      mbs_pkg::ST_RECV: begin
        if (rx_valid_i) begin
          if (rx_cnt_ff < 5'(`MBS_RX_DEPTH)) begin
            nxt_rx_buf[rx_cnt_ff[3:0]] = rx_data_i;
            nxt_rx_cnt = rx_cnt_ff + 5'd1;
          end else begin
            nxt_rx_ovf = 1'b1;
          end
          nxt_crc_d2 = crc_d1_ff;
          nxt_crc_d1 = crc_ff;
          nxt_crc = crc_step(crc_ff, rx_data_i);
          if (rx_last_i) begin
            nxt_state = mbs_pkg::ST_EXEC;
          end
        end
      end
      mbs_pkg::ST_EXEC: begin
        nxt_rx_cnt = 5'd0;
        nxt_rx_ovf = 1'b0;
        nxt_crc = `MBS_CRC_INIT;
        nxt_crc_d1 = `MBS_CRC_INIT;
        nxt_crc_d2 = `MBS_CRC_INIT;
        nxt_tx_idx = 5'd0;
        nxt_tx_crc = `MBS_CRC_INIT;
        nxt_tx_data = nxt_tx_buf[0];
        nxt_tx_last = 1'b0;
        nxt_state = frame_ok ? mbs_pkg::ST_SEND : mbs_pkg::ST_RECV;
      end
      mbs_pkg::ST_SEND: begin
        if (tx_ready_i) begin
          nxt_tx_idx = tx_idx_ff + 5'd1;
          if (tx_idx_ff < tx_len_ff) begin
            nxt_tx_crc = c;
            nxt_tx_data = (tx_idx_ff + 5'd1 < tx_len_ff) ?
                          tx_buf_ff[tx_idx_ff + 5'd1] : c[7:0];
          end else if (tx_idx_ff == tx_len_ff) begin
            nxt_tx_data = tx_crc_ff[15:8];
            nxt_tx_last = 1'b1;
          end else begin
            nxt_tx_last = 1'b0;
            nxt_state = mbs_pkg::ST_RECV;
          end
        end
      end
      default: nxt_state = mbs_pkg::ST_RECV;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= mbs_pkg::ST_RECV;
      rx_buf_ff <= '{default: 8'h00};
      rx_cnt_ff <= 5'd0;
      rx_ovf_ff <= 1'b0;
      crc_ff <= `MBS_CRC_INIT;
      crc_d1_ff <= `MBS_CRC_INIT;
      crc_d2_ff <= `MBS_CRC_INIT;
      tx_buf_ff <= '{default: 8'h00};
      tx_len_ff <= `MBS_EXC_LEN;
      tx_idx_ff <= 5'd0;
      tx_crc_ff <= `MBS_CRC_INIT;
      tx_data_ff <= 8'h00;
      tx_last_ff <= 1'b0;
      exc_ff <= 8'h00;
      coil_ff <= `MBS_COIL_RST;
      hreg_ff <= '{default: `MBS_HREG_RST};
      din_s1_ff <= 16'h0000;
      din_s2_ff <= 16'h0000;
      din_s3_ff <= 16'h0000;
      din_ff <= 16'h0000;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      rx_buf_ff <= nxt_rx_buf;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_ovf_ff <= nxt_rx_ovf;
      crc_ff <= nxt_crc;
      crc_d1_ff <= nxt_crc_d1;
      crc_d2_ff <= nxt_crc_d2;
      tx_idx_ff <= nxt_tx_idx;
      tx_crc_ff <= nxt_tx_crc;
      tx_data_ff <= nxt_tx_data;
      tx_last_ff <= nxt_tx_last;
      din_s1_ff <= din_i;
      din_s2_ff <= din_s1_ff;
      din_s3_ff <= din_s2_ff;
      din_ff <= nxt_din;
      // Execution results land only for an accepted frame
      if (state_ff == mbs_pkg::ST_EXEC && frame_ok) begin
        tx_buf_ff <= nxt_tx_buf;
        tx_len_ff <= nxt_tx_len;
        exc_ff <= nxt_exc;
        coil_ff <= nxt_coil;
        hreg_ff <= nxt_hreg;
      end
    end
  end

  // Port drive
  assign rx_ready_o = (state_ff == mbs_pkg::ST_RECV);
  assign tx_valid_o = (state_ff == mbs_pkg::ST_SEND);
  assign tx_data_o = tx_data_ff;
  assign tx_last_o = tx_last_ff;
  assign coil_o = coil_ff;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      hreg_o[16 * i +: 16] = hreg_ff[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  no_talk_over_a: assert property (!(rx_ready_o && tx_valid_o))
    else $error("request taken while answering");

  crc_drop_a: assert property ((state_ff == mbs_pkg::ST_EXEC && !frame_ok)
    |=> state_ff == mbs_pkg::ST_RECV && $stable(coil_o) && $stable(hreg_o))
    else $error("bad frame not dropped");

  ill_func_a: assert property ((state_ff == mbs_pkg::ST_EXEC && frame_ok
    && fc > `MBS_FC_WR_HREG && fc != `MBS_FC_WR_COILS)
    |=> exc_ff == `MBS_EX_ILL_FUNC)
    else $error("illegal function not reported");

  exc_shape_a: assert property ((state_ff == mbs_pkg::ST_SEND && exc_ff != 8'h00)
    |-> tx_len_ff == `MBS_EXC_LEN && tx_buf_ff[1][7] && tx_buf_ff[2] == exc_ff)
    else $error("exception answer malformed");

  busy_code_a: assert property ((state_ff == mbs_pkg::ST_EXEC && frame_ok && prog_busy_i
    && fc >= `MBS_FC_RD_COILS && fc <= `MBS_FC_WR_HREG) |=> exc_ff == `MBS_EX_BUSY)
    else $error("busy not reported");

  coil_force_a: assert property ((state_ff == mbs_pkg::ST_EXEC && frame_ok
    && fc == `MBS_FC_WR_COIL && nxt_exc == 8'h00 && start < 16'h0010)
    |=> coil_o[$past(start[3:0])] == ($past(qty) == `MBS_COIL_ON))
    else $error("single coil not forced");

  reg_write_a: assert property ((state_ff == mbs_pkg::ST_EXEC && frame_ok
    && fc == `MBS_FC_WR_HREG && nxt_exc == 8'h00 && start < 16'h0008)
    |=> hreg_ff[$past(start[2:0])] == $past(qty))
    else $error("register not written");

  fail_code_a: assert property ((state_ff == mbs_pkg::ST_EXEC && frame_ok && fault_i
    && !prog_busy_i && !prog_nak_i && fc == `MBS_FC_WR_HREG && start < 16'h0008)
    |=> exc_ff == `MBS_EX_DEV_FAIL && $stable(hreg_o))
    else $error("device failure not reported");

  crc_tail_a: assert property ((tx_valid_o && tx_ready_i && tx_idx_ff == tx_len_ff)
    |=> tx_last_o && tx_data_o == tx_crc_ff[15:8])
    else $error("crc tail wrong");

  // Stream ends once the last byte is taken, then listens again
  frame_end_a: assert property ((tx_valid_o && tx_ready_i && tx_last_o)
    |=> !tx_valid_o && rx_ready_o)
    else $error("answer did not end");

  // An answer only starts right after the execute step of a taken query
  answer_only_a: assert property ($rose(tx_valid_o)
    |-> $past(state_ff) == mbs_pkg::ST_EXEC)
    else $error("answer without a query");

endmodule : mbs_request_handler

`default_nettype wire

// >>> tb/mbs_host_model.sv
// Host master model: sends query frames and collects answer frames
`timescale 1ns/1ps
`default_nettype none

module mbs_host_model (
  // Clock
  input wire logic clk_i,
  // Query stream towards the handler
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  input wire logic rx_ready_i,
  // Answer stream from the handler
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic [7:0] resp[$];
  logic done;
  int stuck;

  // Idle lines at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_last_o = 1'b0;
    tx_ready_o = 1'b0;
    stuck = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Query: whole frame, back to back, CRC already appended by caller
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      rx_valid_o = 1'b1;
      rx_data_o = b[i];
      rx_last_o = (i == b.size() - 1);
      @(negedge clk_i);
      if (!rx_ready_i) stuck++;
      @(posedge clk_i);
      #1;
    end
    // Released data shows the inverse, never the stale byte
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask : send

  ////////////////////////////////////////////////////////////////////////////////
  // Answer: random stalls, byte taken at the edge where both are high
  task automatic recv(input int bound);
    resp.delete();
    done = 1'b0;
    for (int n = 0; n < bound && !done; n++) begin
      tx_ready_o = ($urandom_range(3) != 0);
      @(negedge clk_i);
      if (tx_valid_i && tx_ready_o) begin
        resp.push_back(tx_data_i);
        done = tx_last_i;
      end
      @(posedge clk_i);
      #1;
    end
    tx_ready_o = 1'b0;
  endtask : recv
endmodule : mbs_host_model

`default_nettype wire

// >>> tb/mbs_request_handler_tb.sv
// Self-checking bench of the Modbus slave request handler
`include "mbs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mbs_request_handler_tb;
  logic sys_clk_i, resetn_i, ce, fault, long_op, busy, nak, perr;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [15:0] din, coil, cm, d;
  logic [127:0] ireg, hreg;
  logic [15:0] hm [8];
  logic [7:0] rq[$], ex[$];
  int n_mismatch, compares, a, q, f;
  int rdt[8] = '{'h010010, 'h010503, 'h020010, 'h020907, 'h030008, 'h030701, 'h040008,
    'h040503};
  int cwt[3] = '{'h001, 'h0f1, 'h000};
  logic [42:0] ext[12] = '{43'h0_07_00_0001_01, 43'h0_10_00_0001_01, 43'h0_03_07_0002_02,
    43'h0_01_10_0001_02, 43'h0_03_00_0009_03, 43'h0_01_00_0000_03, 43'h0_05_00_1234_03,
    43'h1_06_02_5a5a_04, 43'h2_06_03_a5a5_05, 43'h3_03_00_0001_06, 43'h4_03_00_0001_07,
    43'h5_04_00_0001_08};

  mbs_request_handler i_mbs_request_handler (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .ce_i(ce), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last),
    .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last),
    .tx_ready_i(tx_ready), .din_i(din), .ireg_i(ireg), .coil_o(coil), .hreg_o(hreg),
    .fault_i(fault), .long_op_i(long_op), .prog_busy_i(busy), .prog_nak_i(nak),
    .parity_err_i(perr));

  mbs_host_model i_mbs_host_model (.clk_i(sys_clk_i), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_last_o(rx_last), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_ready_o(tx_ready));

  // 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one per result width
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp8

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp16

  // Reflected CRC-16 over a byte queue
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `MBS_CRC_INIT;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `MBS_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16

  ////////////////////////////////////////////////////////////////////////////////
  // Query body and the normal answer expected for it
  task automatic build(input logic [7:0] fc, input int a, input logic [15:0] v);
    logic [15:0] bits;
    rq = {`MBS_SLAVE_ADDR, fc, 8'h00, 8'(a), v[15:8], v[7:0]};
    ex = {`MBS_SLAVE_ADDR, fc};
    if (fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_DIN) begin
      bits = ((fc == `MBS_FC_RD_COILS ? cm : din) >> a) & 16'((17'h1 << v) - 1);
      ex.push_back(8'((v + 7) / 8));
      for (int j = 0; j < (v + 7) / 8; j++) ex.push_back(bits[8*j +: 8]);
    end else if (fc == `MBS_FC_RD_HREG || fc == `MBS_FC_RD_IREG) begin
      ex.push_back(8'(2 * v));
      for (int j = a; j < a + v; j++) begin
        bits = (fc == `MBS_FC_RD_HREG) ? hm[j % 8] : ireg[16*(j % 8) +: 16];
        ex.push_back(bits[15:8]);
        ex.push_back(bits[7:0]);
      end
    end else ex = rq;
  endtask : build

  // Exception answer in place of the normal one
  task automatic exc(input logic [7:0] code);
    ex = {`MBS_SLAVE_ADDR, rq[1] | `MBS_EXC_FLAG, code};
  endtask : exc

  // Append CRC, exchange the frame, compare every answer byte
  task automatic go(input bit bad);
    logic [15:0] c;
    c = crc16(rq);
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    if (bad) rq[rq.size() - 1] ^= 8'h01;
    if (ex.size() > 0) begin
      c = crc16(ex);
      ex.push_back(c[7:0]);
      ex.push_back(c[15:8]);
    end
    i_mbs_host_model.send(rq);
    i_mbs_host_model.recv(ex.size() > 0 ? 300 : 40);
    cmp8(8'(i_mbs_host_model.resp.size()), 8'(ex.size()), "length");
    foreach (ex[i]) begin
      if (i < i_mbs_host_model.resp.size()) cmp8(i_mbs_host_model.resp[i], ex[i], "byte");
    end
    if (ex.size() > 0 && !i_mbs_host_model.done) begin
      n_mismatch++;
      $display("MISMATCH t=%0t answer never ended", $time);
      results();
    end
  endtask : go

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    ce = 1'b1;
    {fault, long_op, busy, nak, perr} = 5'b00000;
    n_mismatch = 0;
    compares = 0;
    cm = `MBS_COIL_RST;
    foreach (hm[k]) hm[k] = `MBS_HREG_RST;
    void'($urandom(32'haa99));
    din = 16'($urandom);
    for (int k = 0; k < 4; k++) ireg[32*k +: 32] = $urandom;
    repeat (10) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    cmp8(8'(tx_valid), 8'h00, "idle valid");
    cmp16(coil, cm, "coil reset");
    // Single register writes to every word
    for (int k = 0; k < 8; k++) begin
      hm[k] = 16'($urandom);
      build(`MBS_FC_WR_HREG, k, hm[k]);
      go(0);
      cmp16(hreg[16*k +: 16], hm[k], "hreg");
    end
    // Single coil on at both ends, then coil 0 off
    foreach (cwt[i]) begin
      build(`MBS_FC_WR_COIL, cwt[i][11:4], cwt[i][0] ? `MBS_COIL_ON : `MBS_COIL_OFF);
      go(0);
      cm[cwt[i][11:4]] = cwt[i][0];
      cmp16(coil, cm, "coil");
    end
    $display("test writes done");
    // Runs of coils: all 16 from coil 0, then random start and length
    for (int r = 0; r < 3; r++) begin
      a = (r == 0) ? 0 : $urandom_range(15);
      q = (r == 0) ? 16 : $urandom_range(16 - a, 1);
      d = 16'($urandom) & 16'((17'h1 << q) - 1);
      build(`MBS_FC_WR_COILS, a, q);
      rq.push_back(8'((q + 7) / 8));
      for (int j = 0; j < (q + 7) / 8; j++) rq.push_back(d[8*j +: 8]);
      go(0);
      for (int j = 0; j < q; j++) cm[a + j] = d[j];
      cmp16(coil, cm, "coils");
    end
    // Reads: boundary table, then random
    foreach (rdt[i]) begin
      build(rdt[i][23:16], rdt[i][15:8], rdt[i][7:0]);
      go(0);
    end
    for (int r = 0; r < 6; r++) begin
      f = $urandom_range(4, 1);
      a = $urandom_range(f < 3 ? 15 : 7);
      build(8'(f), a, 16'($urandom_range((f < 3 ? 16 : 8) - a, 1)));
      go(0);
    end
    $display("test reads done");
    // Every exception code, conditions one at a time
    foreach (ext[i]) begin
      {fault, long_op, busy, nak, perr} = 5'b10000 >> (ext[i][42:40] - 1);
      build(ext[i][39:32], ext[i][31:24], ext[i][23:8]);
      exc(ext[i][7:0]);
      go(0);
      if (ext[i][7:0] == `MBS_EX_ACK) hm[ext[i][31:24]] = ext[i][23:8];
    end
    {fault, long_op, busy, nak, perr} = 5'b00000;
    cmp16(coil, cm, "coil after error");
    $display("test exceptions done");
    // Enable low: handler frozen, query ignored, nothing written, no answer
    ce = 1'b0;
    build(`MBS_FC_WR_HREG, 2, ~hm[2]);
    ex.delete();
    go(0);
    ce = 1'b1;
    // Corrupted CRC: dropped, no write, then a good query still answered
    build(`MBS_FC_WR_HREG, 1, ~hm[1]);
    ex.delete();
    go(1);
    for (int k = 0; k < 8; k++) cmp16(hreg[16*k +: 16], hm[k], "hreg kept");
    build(`MBS_FC_RD_HREG, 0, 16'h0008);
    go(0);
    cmp8(8'(i_mbs_host_model.stuck), 8'h00, "refused query bytes");
    $display("test crc done");
    results();
  end
endmodule : mbs_request_handler_tb

`default_nettype wire
